// ===== src/fopc_defines.svh
// constants of the flash operation control block: offsets, fields, timing
// assumes a 50 MHz mclk and a 32-bit plain register port
// Contract
// - a keyed control write starts the chosen cycle at the target location
// - a program cycle writes the word buffer contents to the target location
// - control low byte holds four operation bits, each starting its operation
// - control writes without key 0xA442 in bits 31:16 are ignored
// - the key field reads back as zero
// - commit bit makes pending protection value permanent; zero does nothing
// - commit bit reads one while commit runs, zero after; up to 50 us
// - whole array erase bit erases the main array; zero does nothing
// - whole array erase bit reads one until done; up to 250 ms
// - page erase bit erases the page at the target location
// - page erase bit reads one until done; up to 25 ms
// - program bit writes the word buffer at the target location
// - program bit reads one until done; up to 50 us
// - a raw event reaches the interrupt only when its mask bit is set
// - program done raw bit sets when a write or erase cycle completes
// - access violation raw bit sets on an access against protection
// - masked events are forwarded to the interrupt, unmasked only recorded
// - writing one to a masked bit clears it and its raw bit
`ifndef FOPC_DEFINES_SVH
`define FOPC_DEFINES_SVH

`define FOPC_ADDR_W 12
`define FOPC_OFF_TARGET 12'h000
`define FOPC_OFF_WORD 12'h004
`define FOPC_OFF_CTRL 12'h008
`define FOPC_OFF_RAW 12'h00C
`define FOPC_OFF_MASK 12'h010
`define FOPC_OFF_MCLR 12'h014

`define FOPC_LOC_W 13
`define FOPC_BLOCK_LSB 11
`define FOPC_KEY 16'hA442
`define FOPC_KEY_MSB 31
`define FOPC_KEY_LSB 16

`define FOPC_CTL_PROG 0
`define FOPC_CTL_PERASE 1
`define FOPC_CTL_WHOLE_ARRAY_ERASE 2
`define FOPC_CTL_COMMIT 3

`define FOPC_EV_ACCESS 0
`define FOPC_EV_PROG 1

`define FOPC_RESET_WORD 32'h0000_0000
`define FOPC_RESET_LOC 13'h0000
`define FOPC_RESET_EV 2'h0

`define FOPC_CLK_MHZ 50
`define FOPC_TICK_CYCLES (`FOPC_CLK_MHZ * 1)
`define FOPC_PROG_MAX_US 50
`define FOPC_COMMIT_MAX_US 50
`define FOPC_PERASE_MAX_MS 25
`define FOPC_WHOLE_ARRAY_ERASE_MAX_MS 250
`define FOPC_PERASE_MAX_US (`FOPC_PERASE_MAX_MS * 1000)
`define FOPC_WHOLE_ARRAY_ERASE_MAX_US (`FOPC_WHOLE_ARRAY_ERASE_MAX_MS * 1000)
`define FOPC_LIMIT_W 18

`endif

// ===== src/fopc_pkg.sv
// types shared by the flash operation control block
// assumes nothing beyond the defines header
package fopc_pkg;
	typedef enum logic [1:0] {
		FOPC_OP_PROG,
		FOPC_OP_PERASE,
		FOPC_OP_WHOLE_ARRAY_ERASE,
		FOPC_OP_COMMIT
	} fopc_op_t;

	typedef enum logic {
		FOPC_IDLE,
		FOPC_BUSY
	} fopc_state_t;
endpackage : fopc_pkg

// ===== src/fopc_op_timer.sv
// microsecond timeout counter bounding one flash operation
// assumes start is a one-cycle pulse and limit is stable with it
`include "fopc_defines.svh"
`timescale 1ns/1ps
module fopc_op_timer #(
	parameter int TICK_CYCLES = `FOPC_TICK_CYCLES,
	parameter int LIMIT_W = `FOPC_LIMIT_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// control
	input wire logic start,
	input wire logic stop,
	input wire logic [LIMIT_W-1:0] limit_us,
	// result
	output logic expired
);
	logic [15:0] pre_q;
	logic [LIMIT_W-1:0] left_q;
	logic run_q;
	logic tick;

	assign tick = (pre_q == 16'(TICK_CYCLES - 1));

	// prescaler restarts with each operation so the first tick is a full us
	always_ff @(posedge mclk) begin
		if (srst || start || tick)
			pre_q <= 16'h0000;
		else
			pre_q <= pre_q + 16'h0001;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			run_q <= 1'b0;
			left_q <= '0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start) begin
				run_q <= 1'b1;
				left_q <= limit_us;
			end else if (stop) begin
				run_q <= 1'b0;
			end else if (run_q && tick) begin
				if (left_q <= LIMIT_W'(1)) begin
					run_q <= 1'b0;
					expired <= 1'b1;
				end
				left_q <= left_q - LIMIT_W'(1);
			end
		end
	end
endmodule : fopc_op_timer

// ===== src/fopc_top.sv
// flash operation control: keyed start of program, erase, mass erase and
// protection commit, busy readback, raw and masked event status
// assumes the array answers each start with a done pulse; a missing answer
// is cut off at the documented maximum time
//
// Added by the designer: the strobed register port.
`include "fopc_defines.svh"
`timescale 1ns/1ps
module fopc_top
	import fopc_pkg::*;
#(
	parameter int P_TICK_CYCLES = `FOPC_TICK_CYCLES,
	parameter int P_PROG_MAX_US = `FOPC_PROG_MAX_US,
	parameter int P_COMMIT_MAX_US = `FOPC_COMMIT_MAX_US,
	parameter int P_PERASE_MAX_US = `FOPC_PERASE_MAX_US,
	parameter int P_WHOLE_ARRAY_ERASE_MAX_US = `FOPC_WHOLE_ARRAY_ERASE_MAX_US
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// register port
	input wire logic [`FOPC_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// flash array side
	output logic flash_start,
	output fopc_op_t flash_op,
	output logic [`FOPC_LOC_W-1:0] flash_loc,
	output logic [31:0] flash_wdata,
	output logic flash_commit_sel,
	input wire logic flash_done,
	// protection state and read-path violations
	input wire logic [7:0] program_protect_bits,
	input wire logic fetch_violation,
	// processor interrupt
	output logic flash_irq
);
	localparam int LW = `FOPC_LIMIT_W;

	fopc_state_t state_q;
	fopc_op_t op_q;
	logic [`FOPC_LOC_W-1:0] loc_q;
	logic [31:0] word_q;
	logic [1:0] mask_q;
	logic [1:0] raw_q;
	logic [1:0] raw_d;
	logic [3:0] busy_q;
	logic key_ok;
	logic ctl_wr;
	logic start_req;
	logic start_ok;
	logic start_blocked;
	fopc_op_t req_op;
	logic [LW-1:0] req_limit;
	logic op_end;
	logic timer_expired;
	logic [1:0] masked;

	// zero-extends a narrow field onto the 32-bit read bus
	function automatic logic [31:0] fopc_word(input logic [15:0] v);
		fopc_word = {16'h0000, v};
	endfunction : fopc_word

	// true when the 2 KB block holding loc may be programmed or erased
	function automatic logic fopc_prog_allowed(
		input logic [`FOPC_LOC_W-1:0] loc,
		input logic [7:0] prot
	);
		logic [2:0] blk;
		blk = 3'(loc[`FOPC_LOC_W-1:`FOPC_BLOCK_LSB]);
		fopc_prog_allowed = prot[blk];
	endfunction : fopc_prog_allowed

	// truncates a microsecond limit to the timer width
	function automatic logic [LW-1:0] fopc_limit(input int us);
		fopc_limit = LW'(us);
	endfunction : fopc_limit

	// key decode: any control write without the key leaves every bit alone
	assign key_ok = (reg_wdata[`FOPC_KEY_MSB:`FOPC_KEY_LSB] == `FOPC_KEY);
	assign ctl_wr = reg_wr && (reg_addr == `FOPC_OFF_CTRL) && key_ok;
	// only the low four bits start anything; bits 15:4 are dropped
	assign start_req = ctl_wr && (reg_wdata[3:0] != 4'h0);

	// several bits at once is undefined; lowest bit wins here
	always_comb begin
		req_op = FOPC_OP_PROG;
		req_limit = fopc_limit(P_PROG_MAX_US);
		if (reg_wdata[`FOPC_CTL_PROG]) begin
			req_op = FOPC_OP_PROG;
			req_limit = fopc_limit(P_PROG_MAX_US);
		end else if (reg_wdata[`FOPC_CTL_PERASE]) begin
			req_op = FOPC_OP_PERASE;
			req_limit = fopc_limit(P_PERASE_MAX_US);
		end else if (reg_wdata[`FOPC_CTL_WHOLE_ARRAY_ERASE]) begin
			req_op = FOPC_OP_WHOLE_ARRAY_ERASE;
			req_limit = fopc_limit(P_WHOLE_ARRAY_ERASE_MAX_US);
		end else begin
			req_op = FOPC_OP_COMMIT;
			req_limit = fopc_limit(P_COMMIT_MAX_US);
		end
	end

	// program and page erase into a protected block are refused outright
	always_comb begin
		start_blocked = 1'b0;
		if (req_op == FOPC_OP_PROG || req_op == FOPC_OP_PERASE)
			start_blocked = !fopc_prog_allowed(loc_q, program_protect_bits);
	end

	// a new start while one runs is ignored; no queueing
	assign start_ok = start_req && (state_q == FOPC_IDLE) && !start_blocked;
	assign op_end = (state_q == FOPC_BUSY) && (flash_done || timer_expired);

	fopc_op_timer #(
		.TICK_CYCLES(P_TICK_CYCLES),
		.LIMIT_W(LW)
	) u_timer (
		.mclk(mclk),
		.srst(srst),
		.start(start_ok),
		.stop(op_end),
		.limit_us(req_limit),
		.expired(timer_expired)
	);

	// target location register
	always_ff @(posedge mclk) begin
		if (srst)
			loc_q <= `FOPC_RESET_LOC;
		else if (reg_wr && reg_addr == `FOPC_OFF_TARGET)
			loc_q <= reg_wdata[`FOPC_LOC_W-1:0];
	end

	// word buffer register
	always_ff @(posedge mclk) begin
		if (srst)
			word_q <= `FOPC_RESET_WORD;
		else if (reg_wr && reg_addr == `FOPC_OFF_WORD)
			word_q <= reg_wdata;
	end

	// event mask register
	always_ff @(posedge mclk) begin
		if (srst)
			mask_q <= `FOPC_RESET_EV;
		else if (reg_wr && reg_addr == `FOPC_OFF_MASK)
			mask_q <= reg_wdata[1:0];
	end

	// operation sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= FOPC_IDLE;
			op_q <= FOPC_OP_PROG;
		end else begin
			case (state_q)
				FOPC_IDLE: begin
					if (start_ok) begin
						state_q <= FOPC_BUSY;
						op_q <= req_op;
					end
				end
				FOPC_BUSY: begin
					if (op_end)
						state_q <= FOPC_IDLE;
				end
				default: state_q <= FOPC_IDLE;
			endcase
		end
	end

	// busy bits: set by the start, dropped at completion; zero writes do
	// nothing because only a started operation touches them
	always_ff @(posedge mclk) begin
		if (srst) begin
			busy_q <= 4'h0;
		end else if (start_ok) begin
			busy_q <= 4'h0;
			busy_q[req_op] <= 1'b1;
		end else if (op_end) begin
			busy_q <= 4'h0;
		end
	end

	// array request: location, word and commit selection latched at start
	always_ff @(posedge mclk) begin
		if (srst) begin
			flash_start <= 1'b0;
			flash_op <= FOPC_OP_PROG;
			flash_loc <= `FOPC_RESET_LOC;
			flash_wdata <= `FOPC_RESET_WORD;
			flash_commit_sel <= 1'b0;
		end else begin
			flash_start <= start_ok;
			if (start_ok) begin
				flash_op <= req_op;
				flash_loc <= loc_q;
				flash_wdata <= word_q;
				flash_commit_sel <= loc_q[0];
			end
		end
	end

	// raw events: set beats clear in the same cycle
	always_comb begin
		raw_d = raw_q;
		if (reg_wr && reg_addr == `FOPC_OFF_MCLR)
			raw_d = raw_q & ~reg_wdata[1:0];
		if (op_end && op_q != FOPC_OP_COMMIT)
			raw_d[`FOPC_EV_PROG] = 1'b1;
		if (fetch_violation || (start_req && state_q == FOPC_IDLE &&
			start_blocked))
			raw_d[`FOPC_EV_ACCESS] = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (srst)
			raw_q <= `FOPC_RESET_EV;
		else
			raw_q <= raw_d;
	end

	assign masked = raw_q & mask_q;

	// interrupt moves in the same cycle as the raw bits, and one cycle after a mask write
	always_ff @(posedge mclk) begin
		if (srst)
			flash_irq <= 1'b0;
		else
			flash_irq <= |(raw_d & mask_q);
	end

	// read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`FOPC_OFF_TARGET: reg_rdata <= fopc_word(16'(loc_q));
				`FOPC_OFF_WORD: reg_rdata <= word_q;
				`FOPC_OFF_CTRL: reg_rdata <= fopc_word({12'h000, busy_q});
				`FOPC_OFF_RAW: reg_rdata <= fopc_word({14'h0000, raw_q});
				`FOPC_OFF_MASK: reg_rdata <= fopc_word({14'h0000, mask_q});
				`FOPC_OFF_MCLR: reg_rdata <= fopc_word({14'h0000, masked});
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule : fopc_top

// ===== verif/fopc_top_properties.sv
// port assertions for the flash operation control block
// assumes one mclk domain and shortened timeout parameters
`include "fopc_defines.svh"
`timescale 1ns/1ps
module fopc_top_properties
	import fopc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// register port
	input wire logic [`FOPC_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// array side
	input wire logic flash_start,
	input wire fopc_op_t flash_op,
	input wire logic [`FOPC_LOC_W-1:0] flash_loc,
	input wire logic [31:0] flash_wdata,
	input wire logic flash_commit_sel,
	input wire logic [7:0] program_protect_bits,
	input wire logic flash_irq
);
	logic [31:0] word_q;
	logic [12:0] loc_q;
	logic [1:0] mask_q;
	logic ctl_wr;
	assign ctl_wr = reg_wr && reg_addr == `FOPC_OFF_CTRL;
	// shadows of what software wrote, for the start-time and interrupt compares
	always_ff @(posedge mclk) begin
		if (srst) begin
			word_q <= 32'h0000_0000;
			loc_q <= 13'h0;
			mask_q <= 2'h0;
		end else begin
			if (reg_wr && reg_addr == `FOPC_OFF_WORD)
				word_q <= reg_wdata;
			if (reg_wr && reg_addr == `FOPC_OFF_TARGET)
				loc_q <= reg_wdata[12:0];
			if (reg_wr && reg_addr == `FOPC_OFF_MASK)
				mask_q <= reg_wdata[1:0];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_unkeyed_ignored:
	assert property (ctl_wr && reg_wdata[31:16] != `FOPC_KEY |=> !flash_start)
		else $error("start without key");
	a_start_cause:
	assert property (flash_start |-> $past(ctl_wr && |reg_wdata[3:0]))
		else $error("start without control write");
	a_prog_word:
	assert property (flash_start && flash_op == FOPC_OP_PROG
		|-> flash_wdata == word_q) else $error("wrong program word");
	a_target_loc:
	assert property (flash_start |-> flash_loc == loc_q)
		else $error("wrong target location");
	a_prog_op:
	assert property (flash_start && $past(reg_wdata[0])
		|-> flash_op == FOPC_OP_PROG) else $error("program bit ignored");
	a_commit_sel:
	assert property (flash_start |-> flash_commit_sel == loc_q[0])
		else $error("wrong commit selection");
	a_protect:
	assert property (flash_start && flash_op inside {FOPC_OP_PROG,
		FOPC_OP_PERASE} |-> program_protect_bits[flash_loc[12:11]])
		else $error("protected block started");
	a_key_zero:
	assert property (reg_rd && reg_addr == `FOPC_OFF_CTRL
		|=> reg_rdata[31:4] == 28'h0) else $error("key or reserved read");
	a_irq_masked:
	assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !flash_irq)
		else $error("interrupt while masked");
endmodule : fopc_top_properties

bind fopc_top fopc_top_properties u_props (.mclk, .srst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_start, .flash_op,
	.flash_loc, .flash_wdata, .flash_commit_sel, .program_protect_bits,
	.flash_irq);

// ===== verif/fopc_flash_model.sv
// behavioural flash array: one done pulse lat cycles after each start
// assumes lat is held steady while an operation runs
`timescale 1ns/1ps
module fopc_flash_model (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// link to the controller
	input wire logic flash_start,
	input wire logic [7:0] lat,
	output logic flash_done
);
	logic [7:0] cnt_q;
	// lat of zero never answers, so the controller timeout must end it
	always_ff @(posedge mclk) begin
		if (srst)
			cnt_q <= 8'h00;
		else if (flash_start)
			cnt_q <= lat;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end
	assign flash_done = cnt_q == 8'h01;
endmodule : fopc_flash_model

// ===== verif/tb.sv
// self-checking bench for the flash operation control block
// assumes the array model and shortened timeout parameters
`include "fopc_defines.svh"
`timescale 1ns/1ps
module tb;
	import fopc_pkg::*;
	logic mclk, srst, reg_wr, reg_rd, flash_start, flash_commit_sel;
	logic flash_done, fetch_violation, flash_irq;
	logic [`FOPC_ADDR_W-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, flash_wdata, v;
	logic [`FOPC_LOC_W-1:0] flash_loc;
	logic [7:0] program_protect_bits, lat;
	fopc_op_t flash_op;
	int miscompares = 0, compares = 0, starts = 0, cyc = 0;
	fopc_top #(.P_TICK_CYCLES(2), .P_PROG_MAX_US(4), .P_COMMIT_MAX_US(4),
		.P_PERASE_MAX_US(8), .P_WHOLE_ARRAY_ERASE_MAX_US(16)) dut (.mclk, .srst,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_start,
		.flash_op, .flash_loc, .flash_wdata, .flash_commit_sel, .flash_done,
		.program_protect_bits, .fetch_violation, .flash_irq);
	fopc_flash_model u_flash (.mclk, .srst, .flash_start, .lat, .flash_done);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (flash_start)
			starts <= starts + 1;
		if (cyc == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [11:0] a, logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [11:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// bounded poll; a stuck bit shows up in the caller's idle compare
	task automatic wait_idle();
		for (int i = 0; i < 100; i++) begin
			rd(`FOPC_OFF_CTRL);
			if (v[3:0] === 4'h0)
				break;
		end
	endtask : wait_idle
	task automatic t_reset();
		for (int i = 0; i < 7; i++) begin
			rd(12'(i * 4));
			chk("reset value", 32'h0, v);
		end
	endtask : t_reset
	task automatic t_program();
		int s;
		wr(`FOPC_OFF_MASK, 32'h0000_0002);
		wr(`FOPC_OFF_WORD, 32'hC0DE_5A5A);
		wr(`FOPC_OFF_TARGET, 32'h0000_0124);
		s = starts;
		wr(`FOPC_OFF_CTRL, 32'hA442_0001);
		wr(`FOPC_OFF_CTRL, 32'hA442_0002);
		rd(`FOPC_OFF_CTRL);
		chk("ctrl busy", 32'h1, v);
		wait_idle();
		chk("ctrl idle", 32'h0, v);
		chk("starts", s + 1, starts);
		chk("word", 32'hC0DE_5A5A, flash_wdata);
		chk("loc", 32'h124, flash_loc);
		chk("op", FOPC_OP_PROG, flash_op);
		chk("irq", 32'h1, flash_irq);
		rd(`FOPC_OFF_RAW);
		chk("raw", 32'h2, v);
		rd(`FOPC_OFF_MCLR);
		chk("masked", 32'h2, v);
		wr(`FOPC_OFF_MCLR, 32'h0000_0002);
		rd(`FOPC_OFF_RAW);
		chk("raw clear", 32'h0, v);
		chk("irq clear", 32'h0, flash_irq);
	endtask : t_program
	task automatic t_ops();
		logic [7:0] lats [3] = '{8'h0C, 8'h00, 8'h03};
		for (int b = 1; b < 4; b++) begin
			wr(`FOPC_OFF_TARGET, 32'h0000_0401);
			lat <= lats[b-1];
			wr(`FOPC_OFF_CTRL, 32'hA442_0000 | (32'h1 << b));
			#1 chk("op", b, flash_op);
			if (b == 3)
				chk("commit sel", 32'h1, flash_commit_sel);
			rd(`FOPC_OFF_CTRL);
			chk("busy", 32'h1 << b, v);
			wait_idle();
			chk("idle", 32'h0, v);
			rd(`FOPC_OFF_RAW);
			chk("raw", b == 3 ? 32'h0 : 32'h2, v);
			wr(`FOPC_OFF_MCLR, 32'h0000_0002);
		end
	endtask : t_ops
	task automatic t_refuse();
		int s;
		s = starts;
		wr(`FOPC_OFF_CTRL, 32'hA441_0001);
		wr(`FOPC_OFF_CTRL, 32'h0000_0002);
		wr(`FOPC_OFF_CTRL, 32'hA442_00F0);
		program_protect_bits <= 8'hFD;
		wr(`FOPC_OFF_TARGET, 32'h0000_0800);
		wr(`FOPC_OFF_CTRL, 32'hA442_0001);
		rd(`FOPC_OFF_CTRL);
		chk("ctrl", 32'h0, v);
		chk("starts", s, starts);
		rd(`FOPC_OFF_RAW);
		chk("raw access", 32'h1, v);
		wr(`FOPC_OFF_MCLR, 32'h0000_0001);
		rd(`FOPC_OFF_RAW);
		chk("raw clear", 32'h0, v);
		wr(`FOPC_OFF_MASK, 32'h0000_0003);
		fetch_violation <= 1'b1;
		@(posedge mclk);
		fetch_violation <= 1'b0;
		rd(`FOPC_OFF_RAW);
		chk("raw fetch", 32'h1, v);
		chk("irq", 32'h1, flash_irq);
		wr(`FOPC_OFF_MCLR, 32'h0000_0001);
		program_protect_bits <= 8'hFF;
	endtask : t_refuse
	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 32'h0;
		program_protect_bits = 8'hFF;
		fetch_violation = 1'b0;
		lat = 8'h05;
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		t_reset();
		t_program();
		t_ops();
		t_refuse();
		report_and_stop();
	end
endmodule : tb
